// ===== hw/rtc_defines.svh
// constants of the timekeeping core: offsets, fields, reset values, timing
// assumes: included by the package and both design modules
// What this block does
// - fast trim: cycle every four minutes, seconds 00 up
// - magnitudes above 60 pile into second 59
// - trim pulse 1/1024 s wide, 1/512 s apart
// - sub-1024 Hz clocks corrected, faster clocks untouched
// - scratch byte at 03h, default zero
// - seconds at 04h in BCD, default zero
// - seconds bit 7 is halt flag, reset 1
// - halt flag set while oscillator stopped or starting
// - flag clears by write only if oscillator runs
// - minutes at 05h in BCD, bit 7 zero
// - 12-hour format: meridiem bit 5, tens bit 4
// - 24-hour format tens bits 5:4, selectable
// - day of month at 07h in BCD, default 1
// - year divisible by four gives February 29
// - weekday at 08h, 0 to 6, daily count
// - weekday counts cyclically, default code 000
// - trim value seven-bit signed, bit 7 fast mode
// - correction adds or drops ticks, oscillator unchanged
// - trim pulses reach interrupt only when enabled
// - access freezes counters, one second tick kept
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH
`define RTC_ADDR_TRIM       8'h02
`define RTC_ADDR_SCRATCH    8'h03
`define RTC_ADDR_SECONDS    8'h04
`define RTC_ADDR_MINUTES    8'h05
`define RTC_ADDR_HOURS      8'h06
`define RTC_ADDR_DAY        8'h07
`define RTC_ADDR_WEEKDAY    8'h08
`define RTC_HALT_BIT        7
`define RTC_TRIM_MODE_BIT   7
`define RTC_RST_SCRATCH     8'h00
`define RTC_RST_TRIM        8'h00
`define RTC_RST_DAY         6'h01
`define RTC_RST_WEEKDAY     3'h0
`define RTC_REF_PERIOD_NS   25
`define RTC_OSC_TIMEOUT_NS  100000
`define RTC_OSC_TIMEOUT_CYC 12'((`RTC_OSC_TIMEOUT_NS + `RTC_REF_PERIOD_NS - 1) / `RTC_REF_PERIOD_NS)
`define RTC_OSC_STABLE_TICKS 11'h400
`define RTC_OSC_HZ          32768
`define RTC_PULSE_PER_S     1024
`define RTC_PULSE_TICKS     6'(`RTC_OSC_HZ / `RTC_PULSE_PER_S)
`define RTC_TRIM_SINGLE_MAX 7'h3C
`define RTC_LAST_SECOND     7'h3B
`define RTC_MAX_SEC59_PULSES 3'h5
`endif

// ===== hw/rtc_pkg.sv
// types and shared arithmetic of the timekeeping core
// assumes: rtc_defines.svh is on the include path
`include "rtc_defines.svh"
package rtc_pkg;
  typedef struct packed {
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_s3;
    logic [11:0] to_cnt;
    logic [10:0] stable_cnt;
    logic        halted;
    logic        osf;
    logic [14:0] raw_div;
    logic [14:0] presc;
    logic        pending;
    logic [6:0]  sec;
    logic [6:0]  min;
    logic [5:0]  hour;
    logic [5:0]  day;
    logic [2:0]  wday;
    logic [7:0]  scratch;
    logic [7:0]  trim;
    logic [7:0]  rd_data;
    logic        day_carry;
    logic        int_n;
    logic [5:0]  clk_bits;
  } rtc_core_state_t;

  typedef struct packed {
    logic [2:0] fired_cnt;
    logic [5:0] irq_cnt;
  } rtc_trim_state_t;

  function automatic logic [6:0] rtc_bcd_to_bin(input logic [7:0] v);
    logic [6:0] t;
    t = {3'h0, v[7:4]};
    return 7'((t << 3) + (t << 1) + {3'h0, v[3:0]});
  endfunction : rtc_bcd_to_bin
endpackage : rtc_pkg

// ===== hw/rtc_trim.sv
// fast-mode correction pulse generator
// assumes: osc_tick is a one-cycle strobe per rising oscillator edge, presc the
// corrected sub-second position, sec and min the live BCD counters
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.svh"
module rtc_trim
  import rtc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        osc_tick,
  input  wire logic [14:0] presc,
  input  wire logic [6:0]  sec,
  input  wire logic [6:0]  min,
  input  wire logic [7:0]  trim,
  output logic             corr_fire,
  output logic             corr_irq
);
  rtc_trim_state_t state_reg;
  rtc_trim_state_t state_next;
  logic [6:0]      mag;
  logic [6:0]      sec_bin;
  logic [6:0]      min_bin;
  logic [2:0]      count;

  always_comb begin
    state_next = state_reg;
    mag = trim[6] ? 7'(-trim[6:0]) : trim[6:0];
    sec_bin = rtc_bcd_to_bin({1'b0, sec});
    min_bin = rtc_bcd_to_bin({1'b0, min});
    count = 3'h0;
    if (sec_bin < `RTC_LAST_SECOND) begin
      count = (sec_bin < mag) ? 3'h1 : 3'h0;
    end else if (sec_bin == `RTC_LAST_SECOND && mag >= `RTC_TRIM_SINGLE_MAX) begin
      count = 3'(mag - `RTC_LAST_SECOND);
    end
    // pulse k starts at tick k*64 of the second
    corr_fire = trim[`RTC_TRIM_MODE_BIT] && (min_bin[1:0] == 2'h0) && osc_tick
                && (presc[5:0] == 6'h00) && (presc[14:6] == {6'h00, state_reg.fired_cnt})
                && (state_reg.fired_cnt < count);
    if (osc_tick && presc == 15'h7FFF) begin
      state_next.fired_cnt = 3'h0;
    end else if (corr_fire) begin
      state_next.fired_cnt = 3'(state_reg.fired_cnt + 3'h1);
    end
    if (corr_fire) begin
      state_next.irq_cnt = `RTC_PULSE_TICKS;
    end else if (osc_tick && state_reg.irq_cnt != 6'h00) begin
      state_next.irq_cnt = 6'(state_reg.irq_cnt - 6'h01);
    end
    corr_irq = (state_reg.irq_cnt != 6'h00);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  a_fast_mode_only: assert property (@(posedge clk) disable iff (rst)
    !trim[`RTC_TRIM_MODE_BIT] |-> !corr_fire) else $error("trim pulse outside fast mode");
  a_one_per_second: assert property (@(posedge clk) disable iff (rst)
    (sec_bin < `RTC_LAST_SECOND) |-> state_reg.fired_cnt <= 3'h1) else $error("extra pulse");
  a_sec59_limit: assert property (@(posedge clk) disable iff (rst)
    state_reg.fired_cnt <= `RTC_MAX_SEC59_PULSES) else $error("too many pulses in second");
  a_irq_width: assert property (@(posedge clk) disable iff (rst)
    corr_fire |=> state_reg.irq_cnt == 6'h20 && corr_irq) else $error("irq width not loaded");
endmodule : rtc_trim
`default_nettype wire

// ===== hw/rtc_core.sv
// timekeeping core: oscillator watch, prescaler, BCD calendar counters,
// register file and fast trim
// assumes: register strobes come from a serial front end on REF_CLK; the
// oscillator arrives as a raw level on OSC_IN; months and years live outside
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.svh"
module rtc_core
  import rtc_pkg::*;
(
  input  wire logic       REF_CLK,
  input  wire logic       SYS_RST,
  input  wire logic       OSC_IN,
  input  wire logic       ACCESS_ACTIVE,
  input  wire logic       REG_WR,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       HOUR_MODE_12,
  input  wire logic       TRIM_IRQ_ENABLE,
  input  wire logic [4:0] MONTH_BCD,
  input  wire logic [7:0] YEAR_BCD,
  output logic [7:0]      REG_RDATA,
  output logic            INT_N,
  output logic            DAY_CARRY,
  output logic            OSC_HALTED,
  output logic            CLOCK_OUTPUT_PIN_1HZ,
  output logic            CLOCK_OUTPUT_PIN_1024HZ,
  output logic            TMR_SRC_4096HZ,
  output logic            TMR_SRC_64HZ,
  output logic            TMR_SRC_1HZ,
  output logic            TMR_SRC_MINUTE
);
  rtc_core_state_t state_reg;
  rtc_core_state_t state_next;
  logic            osc_tick;
  logic            sec_tick;
  logic            corr_fire;
  logic            corr_irq;
  logic            adv_sec;
  logic            adv_min;
  logic            adv_hour;
  logic            adv_day;
  logic            wr_sec;
  logic            wr_min;
  logic            wr_hour;
  logic            wr_day;
  logic            wr_wday;
  logic [7:0]      sec_up;
  logic [7:0]      min_up;
  logic [7:0]      hour_up;
  logic [7:0]      day_up;
  logic [5:0]      hour_new;
  logic [14:0]     presc_step;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {4'(v[7:4] + 4'h1), 4'h0};
    end
    return {v[7:4], 4'(v[3:0] + 4'h1)};
  endfunction : bcd_inc

  function automatic logic [5:0] last_day(input logic [4:0] month,
                                          input logic [7:0] year);
    logic [6:0] yb;
    yb = rtc_bcd_to_bin(year);
    unique case (month)
      5'h02:                      return (yb[1:0] == 2'h0) ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: return 6'h30;
      default:                    return 6'h31;
    endcase
  endfunction : last_day

  // next hour value and day carry in either format
  function automatic logic [6:0] hour_step(input logic [5:0] h,
                                           input logic       fmt12);
    logic [7:0] t;
    t = bcd_inc({2'h0, h});
    if (fmt12) begin
      if (h[4:0] == 5'h12) begin
        return {1'b0, h[5], 5'h01};
      end
      if (h[4:0] == 5'h11) begin
        return {h[5], ~h[5], 5'h12};
      end
      return {1'b0, h[5], t[4:0]};
    end
    if (h == 6'h23) begin
      return {1'b1, 6'h00};
    end
    return {1'b0, t[5:0]};
  endfunction : hour_step

  rtc_trim u_trim (
    .clk       (REF_CLK),
    .rst       (SYS_RST),
    .osc_tick  (osc_tick),
    .presc     (state_reg.presc),
    .sec       (state_reg.sec),
    .min       (state_reg.min),
    .trim      (state_reg.trim),
    .corr_fire (corr_fire),
    .corr_irq  (corr_irq)
  );

  always_comb begin
    state_next = state_reg;
    // two-stage sync, third stage only for edge detect
    state_next.osc_s1 = OSC_IN;
    state_next.osc_s2 = state_reg.osc_s1;
    state_next.osc_s3 = state_reg.osc_s2;
    osc_tick = state_reg.osc_s2 & ~state_reg.osc_s3;

    // oscillator watch: missing edges or too few stable edges mean halted
    if (osc_tick) begin
      state_next.to_cnt = 12'h000;
    end else if (state_reg.to_cnt != `RTC_OSC_TIMEOUT_CYC) begin
      state_next.to_cnt = 12'(state_reg.to_cnt + 12'h001);
    end
    if (state_reg.to_cnt == `RTC_OSC_TIMEOUT_CYC) begin
      state_next.stable_cnt = 11'h000;
    end else if (osc_tick && state_reg.stable_cnt != `RTC_OSC_STABLE_TICKS) begin
      state_next.stable_cnt = 11'(state_reg.stable_cnt + 11'h001);
    end
    state_next.halted = (state_next.stable_cnt != `RTC_OSC_STABLE_TICKS);

    // corrected prescaler: a trim pulse adds or swallows one tick
    presc_step = 15'h0001;
    if (corr_fire) begin
      presc_step = state_reg.trim[6] ? 15'h0000 : 15'h0002;
    end
    sec_tick = osc_tick && (state_reg.presc == 15'h7FFF);
    if (osc_tick) begin
      state_next.raw_div = 15'(state_reg.raw_div + 15'h0001);
      state_next.presc = 15'(state_reg.presc + presc_step);
    end

    // counters freeze during an access; one tick is held back
    adv_sec = !ACCESS_ACTIVE && (sec_tick || state_reg.pending);
    if (ACCESS_ACTIVE) begin
      state_next.pending = state_reg.pending || sec_tick;
    end else begin
      state_next.pending = state_reg.pending && sec_tick;
    end

    sec_up = bcd_inc({1'b0, state_reg.sec});
    min_up = bcd_inc({1'b0, state_reg.min});
    day_up = bcd_inc({2'h0, state_reg.day});
    hour_up = {1'b0, hour_step(state_reg.hour, HOUR_MODE_12)};
    hour_new = hour_up[5:0];
    adv_min = adv_sec && (state_reg.sec == 7'h59);
    adv_hour = adv_min && (state_reg.min == 7'h59);
    adv_day = adv_hour && hour_up[6];

    if (adv_sec) begin
      state_next.sec = (state_reg.sec == 7'h59) ? 7'h00 : sec_up[6:0];
    end
    if (adv_min) begin
      state_next.min = (state_reg.min == 7'h59) ? 7'h00 : min_up[6:0];
    end
    if (adv_hour) begin
      state_next.hour = hour_new;
    end
    if (adv_day) begin
      if (state_reg.day >= last_day(MONTH_BCD, YEAR_BCD)) begin
        state_next.day = `RTC_RST_DAY;
      end else begin
        state_next.day = day_up[5:0];
      end
      state_next.wday = (state_reg.wday == 3'h6) ? 3'h0 : 3'(state_reg.wday + 3'h1);
    end
    state_next.day_carry = adv_day && (state_reg.day >= last_day(MONTH_BCD, YEAR_BCD));

    // host writes take priority over counting
    wr_sec = REG_WR && (REG_ADDR == `RTC_ADDR_SECONDS);
    wr_min = REG_WR && (REG_ADDR == `RTC_ADDR_MINUTES);
    wr_hour = REG_WR && (REG_ADDR == `RTC_ADDR_HOURS);
    wr_day = REG_WR && (REG_ADDR == `RTC_ADDR_DAY);
    wr_wday = REG_WR && (REG_ADDR == `RTC_ADDR_WEEKDAY);
    if (REG_WR && REG_ADDR == `RTC_ADDR_SCRATCH) begin
      state_next.scratch = REG_WDATA;
    end
    if (REG_WR && REG_ADDR == `RTC_ADDR_TRIM) begin
      state_next.trim = REG_WDATA;
    end
    if (wr_sec) begin
      state_next.sec = REG_WDATA[6:0];
    end
    if (wr_min) begin
      state_next.min = REG_WDATA[6:0];
    end
    if (wr_hour) begin
      state_next.hour = REG_WDATA[5:0];
    end
    if (wr_day) begin
      state_next.day = REG_WDATA[5:0];
    end
    if (wr_wday) begin
      state_next.wday = REG_WDATA[2:0];
    end

    // halt flag: a running halt beats the host clear
    if (state_next.halted) begin
      state_next.osf = 1'b1;
    end else if (wr_sec) begin
      state_next.osf = REG_WDATA[`RTC_HALT_BIT];
    end

    // read mux, unused bits and unmapped addresses read zero
    unique case (REG_ADDR)
      `RTC_ADDR_TRIM:     state_next.rd_data = state_reg.trim;
      `RTC_ADDR_SCRATCH:  state_next.rd_data = state_reg.scratch;
      `RTC_ADDR_SECONDS:  state_next.rd_data = {state_reg.osf, state_reg.sec};
      `RTC_ADDR_MINUTES:  state_next.rd_data = {1'b0, state_reg.min};
      `RTC_ADDR_HOURS:    state_next.rd_data = {2'h0, state_reg.hour};
      `RTC_ADDR_DAY:      state_next.rd_data = {2'h0, state_reg.day};
      `RTC_ADDR_WEEKDAY:  state_next.rd_data = {5'h00, state_reg.wday};
      default:            state_next.rd_data = 8'h00;
    endcase

    state_next.int_n = !(corr_irq && TRIM_IRQ_ENABLE);
    // bit order: 1 Hz out, 1024 Hz out, 4096 Hz, 64 Hz, 1 Hz, minute
    state_next.clk_bits = {state_next.presc[14],
                           state_next.raw_div[4],
                           state_next.raw_div[2],
                           state_next.presc[8],
                           state_next.presc[14],
                           (state_next.sec[6:4] < 3'h3)};
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= '0;
      state_reg.halted <= 1'b1;
      state_reg.osf <= 1'b1;
      state_reg.day <= `RTC_RST_DAY;
      state_reg.wday <= `RTC_RST_WEEKDAY;
      state_reg.scratch <= `RTC_RST_SCRATCH;
      state_reg.trim <= `RTC_RST_TRIM;
      state_reg.int_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign REG_RDATA = state_reg.rd_data;
  assign INT_N = state_reg.int_n;
  assign DAY_CARRY = state_reg.day_carry;
  assign OSC_HALTED = state_reg.halted;
  assign CLOCK_OUTPUT_PIN_1HZ = state_reg.clk_bits[5];
  assign CLOCK_OUTPUT_PIN_1024HZ = state_reg.clk_bits[4];
  assign TMR_SRC_4096HZ = state_reg.clk_bits[3];
  assign TMR_SRC_64HZ = state_reg.clk_bits[2];
  assign TMR_SRC_1HZ = state_reg.clk_bits[1];
  assign TMR_SRC_MINUTE = state_reg.clk_bits[0];

  a_scratch_store: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (REG_WR && REG_ADDR == `RTC_ADDR_SCRATCH) |=> ##1 REG_RDATA == $past(REG_WDATA, 2)
      || $past(REG_ADDR) != `RTC_ADDR_SCRATCH) else $error("scratch byte not stored");
  a_halt_sets_flag: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    state_reg.halted |-> state_reg.osf) else $error("halt flag missing while halted");
  a_flag_clear_run: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (wr_sec && !REG_WDATA[`RTC_HALT_BIT] && !state_next.halted) |=> !state_reg.osf)
    else $error("halt flag clear ignored");
  a_minute_bit7: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (REG_ADDR == `RTC_ADDR_MINUTES) |=> !REG_RDATA[7]) else $error("minutes bit 7 set");
  a_access_freeze: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (ACCESS_ACTIVE && !REG_WR) |=> state_reg.sec == $past(state_reg.sec))
    else $error("seconds moved during access");
  a_sec_rollover: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (adv_sec && state_reg.sec == 7'h59 && !REG_WR) |=> state_reg.sec == 7'h00
      && state_reg.min != $past(state_reg.min)) else $error("seconds carry lost");
  a_weekday_wrap: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (adv_day && state_reg.wday == 3'h6 && !REG_WR) |=> state_reg.wday == 3'h0)
    else $error("weekday did not wrap");
  a_leap_february: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (adv_day && !REG_WR && MONTH_BCD == 5'h02 && state_reg.day == 6'h28
      && rtc_bcd_to_bin(YEAR_BCD) % 4 == 0) |=> state_reg.day == 6'h29)
    else $error("leap day skipped");
  a_irq_gated: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !TRIM_IRQ_ENABLE |=> INT_N) else $error("interrupt pulse while disabled");
  a_trim_step: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (corr_fire && !state_reg.trim[6]) |=> state_reg.presc == 15'($past(state_reg.presc) + 15'h0002))
    else $error("added correction tick missing");
endmodule : rtc_core
`default_nettype wire

// ===== tb/rtc_host_model.sv
// host-side model: drives the register strobe port of the timekeeping core
// assumes: tasks are called by the bench, each call starting after a clk edge
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output logic            acc,
  output logic            wr,
  output logic [7:0]      addr,
  output logic [7:0]      wdata
);
  initial begin
    acc   = 1'b0;
    wr    = 1'b0;
    addr  = 8'h00;
    wdata = 8'h00;
  end
  // burst framing, bench keeps each burst far below one second
  task automatic burst(input logic on);
    @(posedge clk);
    acc <= on;
  endtask : burst
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
    // released data no longer shows the last byte
    wdata <= ~d;
  endtask : write
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    @(posedge clk);
    d = rdata;
  endtask : read
endmodule : rtc_host_model
`default_nettype wire

// ===== tb/rtc_timekeeping_and_fast_trim_tb.sv
// self-checking bench of the timekeeping core
// assumes: oscillator is sped up to one rising edge per two clocks to reach a second
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.svh"
module rtc_timekeeping_and_fast_trim_tb;
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       osc_in  = 1'b0;
  logic       osc_run = 1'b0;
  logic       hour_12 = 1'b0;
  logic       irq_en  = 1'b0;
  logic [4:0] month   = 5'h12;
  logic [7:0] year    = 8'h00;
  logic       acc, wr, int_n, day_carry, osc_halted, minute_src;
  logic       clk_1hz, clk_1024, tmr_4096, tmr_64, tmr_1hz;
  logic [7:0] addr, wdata, rdata, d, e;
  int         err_count = 0;
  int         n_tests   = 0;
  int         i, k;

  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (osc_run)
      osc_in <= ~osc_in;
  end

  rtc_host_model u_rtc_host_model (.clk(ref_clk), .rdata(rdata), .acc(acc), .wr(wr),
    .addr(addr), .wdata(wdata));
  rtc_core u_rtc_core (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .OSC_IN(osc_in),
    .ACCESS_ACTIVE(acc), .REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wdata),
    .HOUR_MODE_12(hour_12), .TRIM_IRQ_ENABLE(irq_en), .MONTH_BCD(month),
    .YEAR_BCD(year), .REG_RDATA(rdata), .INT_N(int_n), .DAY_CARRY(day_carry),
    .OSC_HALTED(osc_halted), .CLOCK_OUTPUT_PIN_1HZ(clk_1hz),
    .CLOCK_OUTPUT_PIN_1024HZ(clk_1024), .TMR_SRC_4096HZ(tmr_4096), .TMR_SRC_64HZ(tmr_64),
    .TMR_SRC_1HZ(tmr_1hz), .TMR_SRC_MINUTE(minute_src));

  function automatic logic [7:0] to_bcd(input int n);
    return 8'((n / 10) * 16 + n % 10);
  endfunction : to_bcd

  task automatic end_sim;
    if (err_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
    u_rtc_host_model.read(a, d);
    chk(d & m, exp, "register read");
  endtask : rd_chk

  task automatic wr_one(input logic [7:0] a, input logic [7:0] v);
    u_rtc_host_model.burst(1'b1);
    u_rtc_host_model.write(a, v);
    u_rtc_host_model.burst(1'b0);
  endtask : wr_one

  task automatic wr_chk(input logic [7:0] a, input logic [7:0] v, input logic [7:0] exp);
    wr_one(a, v);
    rd_chk(a, exp, 8'hFF);
  endtask : wr_chk

  task automatic wait_halt(input logic v);
    for (i = 0; i < 8000 && osc_halted !== v; i++)
      @(posedge ref_clk);
    chk({7'h00, osc_halted}, {7'h00, v}, "oscillator watch");
  endtask : wait_halt

  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    end_sim();
  end

  initial begin
    k = $urandom(32'h9CC228B3);
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk(`RTC_ADDR_TRIM, 8'h00, 8'hFF);
    rd_chk(`RTC_ADDR_SCRATCH, 8'h00, 8'hFF);
    rd_chk(`RTC_ADDR_SECONDS, 8'h80, 8'hFF);
    rd_chk(`RTC_ADDR_MINUTES, 8'h00, 8'hFF);
    rd_chk(`RTC_ADDR_HOURS, 8'h00, 8'hFF);
    rd_chk(`RTC_ADDR_DAY, 8'h01, 8'hFF);
    rd_chk(`RTC_ADDR_WEEKDAY, 8'h00, 8'hFF);
    // clear refused while the oscillator is stopped
    wr_one(`RTC_ADDR_SECONDS, 8'h00);
    rd_chk(`RTC_ADDR_SECONDS, 8'h80, 8'h80);
    osc_run <= 1'b1;
    wait_halt(1'b0);
    rd_chk(`RTC_ADDR_SECONDS, 8'h80, 8'h80);
    wr_one(`RTC_ADDR_SECONDS, 8'h00);
    rd_chk(`RTC_ADDR_SECONDS, 8'h00, 8'h80);
    // oscillator fails in mid-run, then recovers
    osc_run <= 1'b0;
    wait_halt(1'b1);
    rd_chk(`RTC_ADDR_SECONDS, 8'h80, 8'h80);
    osc_run <= 1'b1;
    wait_halt(1'b0);
    wr_one(`RTC_ADDR_SECONDS, 8'h00);
    rd_chk(`RTC_ADDR_SECONDS, 8'h00, 8'h80);
    for (int n = 0; n < 8; n++) begin
      e = 8'($urandom);
      wr_chk(`RTC_ADDR_SCRATCH, e, e);
      k = $urandom % 60;
      wr_chk(`RTC_ADDR_MINUTES, to_bcd(k) | 8'h80, to_bcd(k));
      k = $urandom % 24;
      wr_chk(`RTC_ADDR_HOURS, to_bcd(k) | 8'hC0, to_bcd(k));
      k = $urandom % 31 + 1;
      wr_chk(`RTC_ADDR_DAY, to_bcd(k) | 8'hC0, to_bcd(k));
      k = $urandom % 7;
      wr_chk(`RTC_ADDR_WEEKDAY, 8'(k) | 8'hF8, 8'(k));
    end
    hour_12 <= 1'b1;
    wr_chk(`RTC_ADDR_HOURS, 8'hF2, 8'h32);
    hour_12 <= 1'b0;
    wr_chk(8'h09, 8'($urandom), 8'h00);
    rd_chk(8'h01, 8'h00, 8'hFF);
    // last second of a month end, fast trim +1 armed
    year   <= to_bcd($urandom % 100);
    irq_en <= 1'b1;
    u_rtc_host_model.burst(1'b1);
    u_rtc_host_model.write(`RTC_ADDR_TRIM, 8'h81);
    u_rtc_host_model.write(`RTC_ADDR_SECONDS, 8'h59);
    u_rtc_host_model.write(`RTC_ADDR_MINUTES, 8'h59);
    u_rtc_host_model.write(`RTC_ADDR_HOURS, 8'h23);
    u_rtc_host_model.write(`RTC_ADDR_DAY, 8'h31);
    u_rtc_host_model.write(`RTC_ADDR_WEEKDAY, 8'h06);
    u_rtc_host_model.burst(1'b0);
    repeat (4) @(posedge ref_clk);
    chk({7'h00, minute_src}, 8'h00, "minute source");
    chk({7'h00, int_n}, 8'h01, "trim idle");
    for (i = 0; i < 70000 && day_carry !== 1'b1; i++)
      @(posedge ref_clk);
    chk({7'h00, day_carry}, 8'h01, "day carry");
    @(posedge ref_clk);
    chk({7'h00, day_carry}, 8'h00, "day carry width");
    for (i = 0; i < 100 && int_n !== 1'b0; i++)
      @(posedge ref_clk);
    for (k = 0; k < 200 && int_n === 1'b0; k++)
      @(posedge ref_clk);
    n_tests++;
    if (k < 8'h3E || k > 8'h46) begin
      err_count++;
      $display("mismatch at %0t: trim pulse low for %0d clocks", $time, k);
    end
    rd_chk(`RTC_ADDR_SECONDS, 8'h00, 8'hFF);
    rd_chk(`RTC_ADDR_MINUTES, 8'h00, 8'hFF);
    rd_chk(`RTC_ADDR_HOURS, 8'h00, 8'hFF);
    rd_chk(`RTC_ADDR_DAY, 8'h01, 8'hFF);
    rd_chk(`RTC_ADDR_WEEKDAY, 8'h00, 8'hFF);
    chk({7'h00, minute_src}, 8'h01, "minute source");
    // early in the second: corrected clocks still in their low half
    chk({5'h00, clk_1hz, tmr_1hz, tmr_64}, 8'h00, "corrected clocks");
    e = {6'h00, clk_1024, tmr_4096};
    repeat (8) @(posedge ref_clk);
    chk({7'h00, tmr_4096}, {7'h00, ~e[0]}, "4096 Hz source");
    repeat (24) @(posedge ref_clk);
    chk({7'h00, clk_1024}, {7'h00, ~e[1]}, "1024 Hz output");
    end_sim();
  end
endmodule : rtc_timekeeping_and_fast_trim_tb
`default_nettype wire
